// ---- spi_cmd_map.svh ----
// Operation
// - four-wire mode shifts a byte out per byte in
// - two successive 7Ah bytes reset the port
// - port reset leaves registers and pointer untouched
// - set-address command loads the pointer
// - write command 7Eh stores byte, then increments
// - read returns pointed register, then increments
// - sample on rising edge; clock, data idle high
// - pointer wraps from FFh to 00h
// - bidirectional mode: command phase, then data phase
// - set-address code 7Dh; unknown codes ignored
`ifndef SPI_CMD_MAP_SVH
`define SPI_CMD_MAP_SVH
`define CMD_IF_RESET 8'h7A
`define CMD_SET_ADDR 8'h7D
`define CMD_WRITE 8'h7E
`define CMD_READ 8'h7F
`define PTR_RESET 8'h00
`define PTR_STEP 8'h01
`define LAST_BIT 3'h7
`define HIST_IDLE 15'h7FFF
`define PIN_CS 0
`define PIN_SCK 1
`define PIN_MOSI 2
`define PIN_SDIO 3
`define PIN_MODE 4
`endif

// ---- spi_cmd_pkg.sv ----
package spi_cmd_pkg;
   typedef enum logic [1:0]
   {
      PH_CMD = 2'b00,
      PH_ADDR = 2'b01,
      PH_WDATA = 2'b11,
      PH_RDATA = 2'b10
   } phase_e;

   typedef struct packed
   {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] f;
      phase_e phase;
      logic [2:0] bcnt;
      logic [7:0] shin;
      logic [7:0] shout;
      logic [7:0] ptr;
      logic [14:0] hist;
      logic out;
      logic oe;
      logic we;
      logic [7:0] waddr;
      logic [7:0] wdata;
   } port_s;

   typedef struct packed
   {
      logic [255:0][7:0] mem;
      logic [7:0] rdata;
   } mem_s;
endpackage

// ---- reg_mem.sv ----
`timescale 1ns/1ns
module reg_mem
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write port
   input wire logic we,
   input wire logic [7:0] waddr,
   input wire logic [7:0] wdata,
   // read port
   input wire logic [7:0] raddr,
   output logic [7:0] rdata
);
   import spi_cmd_pkg::*;

   mem_s r;
   mem_s r_nxt;

   always_comb
   begin
      r_nxt = r;
      if (we)
      begin
         r_nxt.mem[waddr] = wdata;
      end
      r_nxt.rdata = r.mem[raddr];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
      end
      else
      begin
         r <= r_nxt;
      end
   end

   assign rdata = r.rdata;
endmodule

// ---- spi_register_command_port.sv ----
`timescale 1ns/1ns
`include "spi_cmd_map.svh"
module spi_register_command_port
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   // shared line and mode strap
   input wire logic shared_serial_data_line_in,
   output logic shared_serial_data_line_out,
   output logic shared_serial_data_line_oe,
   input wire logic bidir_mode,
   // register write notice
   output logic reg_wr_pulse,
   output logic [7:0] reg_wr_addr,
   output logic [7:0] reg_wr_data
);
   import spi_cmd_pkg::*;

   spi_cmd_pkg::port_s r;
   spi_cmd_pkg::port_s r_nxt;
   logic [7:0] rdata;
   logic rise_w;
   logic done_w;
   logic rst_w;
   logic din_w;
   logic [7:0] byte_w;

   reg_mem u_mem
   (
      .clk(clk),
      .rst_n(rst_n),
      .we(r.we),
      .waddr(r.waddr),
      .wdata(r.wdata),
      .raddr(r.ptr),
      .rdata(rdata)
   );

   always_comb
   begin
      r_nxt = r;
      r_nxt.we = 1'b0;
      r_nxt.s1 = {bidir_mode, shared_serial_data_line_in, mosi, sclk, cs_n};
      r_nxt.s2 = r.s1;
      r_nxt.s3 = r.s2;
      for (int i = 0; i < 5; i++)
      begin
         r_nxt.f[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.f[i];
      end
      // sample on rising edge of the filtered clock
      rise_w = r_nxt.f[`PIN_SCK] & ~r.f[`PIN_SCK];
      din_w = r_nxt.f[`PIN_MODE] ? r_nxt.f[`PIN_SDIO] : r_nxt.f[`PIN_MOSI];
      byte_w = {r.shin[6:0], din_w};
      done_w = rise_w && !r_nxt.f[`PIN_CS] && (r.bcnt == `LAST_BIT);
      // reset pair seen on any bit, so a slipped byte count realigns
      rst_w = rise_w && !r_nxt.f[`PIN_CS]
         && ({r.hist, din_w} == {`CMD_IF_RESET, `CMD_IF_RESET});
      if (r_nxt.f[`PIN_CS])
      begin
         // deselected: lines rest high, frame state cleared
         r_nxt.phase = PH_CMD;
         r_nxt.bcnt = 3'h0;
         r_nxt.hist = `HIST_IDLE;
         r_nxt.out = 1'b1;
         r_nxt.oe = 1'b0;
      end
      else if (r.f[`PIN_CS])
      begin
         // first bit ready before the first rising edge
         r_nxt.out = rdata[7];
         r_nxt.shout = {rdata[6:0], 1'b1};
      end
      else if (rise_w)
      begin
         r_nxt.shin = byte_w;
         r_nxt.bcnt = r.bcnt + 3'h1;
         r_nxt.hist = {r.hist[13:0], din_w};
         if (!done_w && !rst_w)
         begin
            r_nxt.out = r.shout[7];
            r_nxt.shout = {r.shout[6:0], 1'b1};
         end
         else
         begin
            // next outgoing byte from the current pointer
            r_nxt.out = rdata[7];
            r_nxt.shout = {rdata[6:0], 1'b1};
            if (rst_w)
            begin
               // only the port state is cleared; next bit opens a byte
               r_nxt.bcnt = 3'h0;
               r_nxt.hist = `HIST_IDLE;
               r_nxt.phase = PH_CMD;
               r_nxt.oe = 1'b0;
            end
            else
            begin
               case (r.phase)
                  PH_CMD:
                  begin
                     case (byte_w)
                        `CMD_SET_ADDR: r_nxt.phase = PH_ADDR;
                        `CMD_WRITE: r_nxt.phase = PH_WDATA;
                        `CMD_READ:
                        begin
                           r_nxt.phase = PH_RDATA;
                           r_nxt.oe = r_nxt.f[`PIN_MODE];
                        end
                        default: r_nxt.phase = PH_CMD;
                     endcase
                  end
                  PH_ADDR:
                  begin
                     r_nxt.ptr = byte_w;
                     r_nxt.phase = PH_CMD;
                  end
                  PH_WDATA:
                  begin
                     r_nxt.we = 1'b1;
                     r_nxt.waddr = r.ptr;
                     r_nxt.wdata = byte_w;
                     r_nxt.ptr = r.ptr + `PTR_STEP;
                     r_nxt.phase = PH_CMD;
                  end
                  PH_RDATA:
                  begin
                     r_nxt.ptr = r.ptr + `PTR_STEP;
                     r_nxt.oe = 1'b0;
                     r_nxt.phase = PH_CMD;
                  end
                  default: r_nxt.phase = PH_CMD;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '{s1: 5'h0F, s2: 5'h0F, s3: 5'h0F, f: 5'h0F, phase: PH_CMD,
                bcnt: 3'h0, shin: 8'h00, shout: 8'hFF, ptr: `PTR_RESET,
                hist: `HIST_IDLE, out: 1'b1, oe: 1'b0, we: 1'b0,
                waddr: 8'h00, wdata: 8'h00};
      end
      else
      begin
         r <= r_nxt;
      end
   end

   assign miso = r.out;
   assign shared_serial_data_line_out = r.out;
   assign shared_serial_data_line_oe = r.oe;
   assign reg_wr_pulse = r.we;
   assign reg_wr_addr = r.waddr;
   assign reg_wr_data = r.wdata;

   a_byte_out: assert property (@(posedge clk)
      disable iff (!rst_n) done_w |=> r.out == $past(rdata[7]))
      else $error("outgoing byte not loaded at byte end");
   a_shift_out: assert property (@(posedge clk)
      disable iff (!rst_n)
      rise_w && !done_w && !rst_w && !r.f[`PIN_CS] && !r_nxt.f[`PIN_CS]
      |=> r.out == $past(r.shout[7]))
      else $error("outgoing bit not shifted on rising edge");
   a_reset_seq: assert property (@(posedge clk)
      disable iff (!rst_n)
      rst_w |=> r.phase == PH_CMD && !r.oe && !r.we && r.bcnt == 3'h0)
      else $error("double reset code did not reset the port");
   a_reset_keeps: assert property (@(posedge clk)
      disable iff (!rst_n) rst_w |=> r.ptr == $past(r.ptr))
      else $error("port reset changed the pointer");
   a_set_addr: assert property (@(posedge clk)
      disable iff (!rst_n) done_w && !rst_w && r.phase == PH_ADDR
      |=> r.ptr == $past(byte_w) && r.phase == PH_CMD)
      else $error("pointer not loaded by set address");
   a_write_store: assert property (@(posedge clk)
      disable iff (!rst_n) done_w && !rst_w && r.phase == PH_WDATA
      |=> r.we && r.waddr == $past(r.ptr) && r.wdata == $past(byte_w)
      && r.ptr == 8'($past(r.ptr) + `PTR_STEP))
      else $error("write did not store and increment");
   a_store_lands: assert property (@(posedge clk)
      disable iff (!rst_n)
      r.we |=> u_mem.r.mem[$past(r.waddr)] == $past(r.wdata))
      else $error("register write did not land");
   a_read_inc: assert property (@(posedge clk)
      disable iff (!rst_n) done_w && !rst_w && r.phase == PH_RDATA
      |=> r.ptr == 8'($past(r.ptr) + `PTR_STEP) && !r.oe)
      else $error("read did not increment pointer");
   a_ptr_wrap: assert property (@(posedge clk)
      disable iff (!rst_n)
      done_w && !rst_w && r.phase == PH_WDATA && r.ptr == 8'hFF
      |=> r.ptr == `PTR_RESET)
      else $error("pointer did not wrap");
   a_idle_high: assert property (@(posedge clk)
      disable iff (!rst_n) r.f[`PIN_CS] |-> r.out && !r.oe)
      else $error("outputs not idle while deselected");
   a_rise_only: assert property (@(posedge clk)
      disable iff (!rst_n) !rise_w |=> $stable(r.shin))
      else $error("data sampled without rising edge");
   a_read_drive: assert property (@(posedge clk)
      disable iff (!rst_n)
      done_w && !rst_w && r.phase == PH_CMD && byte_w == `CMD_READ
      |=> r.phase == PH_RDATA && r.oe == r.f[`PIN_MODE])
      else $error("read command did not turn the shared line");
   a_oe_read: assert property (@(posedge clk)
      disable iff (!rst_n) r.oe |-> r.phase == PH_RDATA && r.f[`PIN_MODE])
      else $error("shared line driven outside read phase");
   a_ignore_cmd: assert property (@(posedge clk)
      disable iff (!rst_n)
      done_w && !rst_w && r.phase == PH_CMD && byte_w != `CMD_SET_ADDR
      && byte_w != `CMD_WRITE && byte_w != `CMD_READ
      |=> r.phase == PH_CMD && $stable(r.ptr) && !r.we)
      else $error("unknown command had an effect");
endmodule

// ---- spi_host.sv ----
`timescale 1ns/1ns
module spi_host
(
   // clock
   input wire logic clk,
   // serial pins
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   // shared line
   output logic sd_drv,
   output logic sd_oe,
   input wire logic sd_line
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      mosi = 1'b1;
      sd_drv = 1'b1;
      sd_oe = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic open_frame(input logic bidir);
      wait_clk(1);
      cs_n = 1'b0;
      sd_oe = bidir;
      wait_clk(8);
   endtask

   // one byte msb first; listen releases the shared line
   task automatic xfer(input logic [7:0] tx, input logic bidir,
      input logic listen, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         wait_clk(4);
         sclk = 1'b0;
         mosi = bidir ? 1'b1 : tx[i];
         sd_oe = bidir & ~listen;
         sd_drv = tx[i];
         wait_clk(4);
         rx[i] = bidir ? sd_line : miso;
         sclk = 1'b1;
      end
   endtask

   // stray low bits that knock the byte count out of step
   task automatic stray(input int n);
      repeat (n)
      begin
         wait_clk(4);
         sclk = 1'b0;
         mosi = 1'b0;
         wait_clk(4);
         sclk = 1'b1;
      end
   endtask

   task automatic close_frame();
      wait_clk(8);
      sd_oe = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b1;
      wait_clk(8);
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ns
`include "spi_cmd_map.svh"
module tb_top;
   logic clk, rst_n, bidir_mode, cs_n, sclk, mosi, miso;
   logic sd_out, sd_oe, sd_drv, h_oe, sd_in, reg_wr_pulse;
   logic [7:0] reg_wr_addr, reg_wr_data, wr_addr, wr_data, rx;
   int num_errors, checked, wr_cnt;
   // pull-up keeps the shared line high when nobody drives
   assign sd_in = sd_oe ? sd_out : (h_oe ? sd_drv : 1'b1);

   spi_register_command_port dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
      .sclk(sclk), .mosi(mosi), .miso(miso),
      .shared_serial_data_line_in(sd_in),
      .shared_serial_data_line_out(sd_out),
      .shared_serial_data_line_oe(sd_oe), .bidir_mode(bidir_mode),
      .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data));
   spi_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
      .miso(miso), .sd_drv(sd_drv), .sd_oe(h_oe), .sd_line(sd_in));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   always @(posedge clk)
      if (reg_wr_pulse === 1'b1)
      begin
         wr_addr <= reg_wr_addr;
         wr_data <= reg_wr_data;
         wr_cnt <= wr_cnt + 1;
      end

   task automatic chk(input string name, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmd2(input logic [7:0] c, d, input logic bd);
      host.open_frame(bd);
      host.xfer(c, bd, 1'b0, rx);
      host.xfer(d, bd, bd && c == `CMD_READ, rx);
      host.close_frame();
   endtask

   task automatic wr(input logic [7:0] d, exp_a, input logic bd);
      cmd2(`CMD_WRITE, d, bd);
      chk("wr_addr", wr_addr, exp_a);
      chk("wr_data", wr_data, d);
   endtask

   task automatic rd(input logic [7:0] exp, input logic bd);
      cmd2(`CMD_READ, 8'h00, bd);
      chk("rd_data", rx, exp);
   endtask

   task automatic t_write_read();
      cmd2(`CMD_SET_ADDR, 8'h10, 1'b0);
      wr(8'hA5, 8'h10, 1'b0);
      wr(8'h3C, 8'h11, 1'b0);
      cmd2(`CMD_SET_ADDR, 8'h10, 1'b0);
      rd(8'hA5, 1'b0);
      rd(8'h3C, 1'b0);
      chk("miso_idle", {7'h00, miso}, 8'h01);
   endtask

   task automatic t_wrap();
      cmd2(`CMD_SET_ADDR, 8'hFF, 1'b0);
      wr(8'h5A, 8'hFF, 1'b0);
      wr(8'h11, 8'h00, 1'b0);
      cmd2(`CMD_SET_ADDR, 8'hFF, 1'b0);
      rd(8'h5A, 1'b0);
      rd(8'h11, 1'b0);
   endtask

   task automatic t_port_reset();
      int n;
      cmd2(`CMD_SET_ADDR, 8'h30, 1'b0);
      n = wr_cnt;
      host.open_frame(1'b0);
      host.stray(3);
      host.xfer(`CMD_IF_RESET, 1'b0, 1'b0, rx);
      host.xfer(`CMD_IF_RESET, 1'b0, 1'b0, rx);
      host.xfer(8'h55, 1'b0, 1'b0, rx);
      host.xfer(`CMD_WRITE, 1'b0, 1'b0, rx);
      host.xfer(8'h99, 1'b0, 1'b0, rx);
      host.close_frame();
      chk("wr_count", 8'(wr_cnt - n), 8'h01);
      chk("wr_addr", wr_addr, 8'h30);
      chk("wr_data", wr_data, 8'h99);
      cmd2(`CMD_SET_ADDR, 8'h10, 1'b0);
      rd(8'hA5, 1'b0);
   endtask

   task automatic t_bidir();
      bidir_mode = 1'b1;
      host.wait_clk(8);
      cmd2(`CMD_SET_ADDR, 8'h10, 1'b1);
      rd(8'hA5, 1'b1);
      wr(8'h42, 8'h11, 1'b1);
      chk("line_oe", {7'h00, sd_oe}, 8'h00);
      bidir_mode = 1'b0;
      host.wait_clk(8);
   endtask

   initial
   begin
      rst_n = 1'b0;
      bidir_mode = 1'b0;
      wr_cnt = 0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      t_write_read();
      t_wrap();
      t_port_reset();
      t_bidir();
      stop_test();
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      num_errors++;
      stop_test();
   end
endmodule
